/* File: fsr_consts.svh */
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH

// ----------------------------------------
// Register word addresses
// ----------------------------------------
`define FSR_A_IN_REG_CNT    16'h1022
`define FSR_A_OUT_REG_CNT   16'h1023
`define FSR_A_IN_BIT_CNT    16'h1024
`define FSR_A_OUT_BIT_CNT   16'h1025
`define FSR_A_IP_METHOD     16'h1028
`define FSR_A_TCP_CONN_CNT  16'h102A
`define FSR_A_SOCK_TIMEOUT  16'h1030
`define FSR_A_HW_ADDR0      16'h1031
`define FSR_A_HW_ADDR1      16'h1032
`define FSR_A_HW_ADDR2      16'h1033
`define FSR_A_RSP_DELAY     16'h1037
`define FSR_A_RUN_STATE     16'h1040
`define FSR_A_WD_CMD        16'h1100
`define FSR_A_WD_STATE      16'h1101
`define FSR_A_WD_TIMEOUT    16'h1102
`define FSR_A_WD_CONFIG     16'h1103
`define FSR_A_WD_MODE       16'h1104
`define FSR_A_CONST_00      16'h2000
`define FSR_A_CONST_01      16'h2001
`define FSR_A_CONST_02      16'h2002
`define FSR_A_CONST_03      16'h2003
`define FSR_A_CONST_04      16'h2004
`define FSR_A_CONST_05      16'h2005
`define FSR_A_CONST_06      16'h2006
`define FSR_A_CONST_07      16'h2007
`define FSR_A_CONST_08      16'h2008
`define FSR_A_FW_REV        16'h2010
`define FSR_A_SERIES        16'h2011
`define FSR_A_DEVICE        16'h2012
`define FSR_A_FW_MAJOR      16'h2013
`define FSR_A_FW_MINOR      16'h2014
`define FSR_A_STACK_VER     16'h2015

// ----------------------------------------
// Constant test patterns
// ----------------------------------------
`define FSR_V_CONST_00      16'h0000
`define FSR_V_CONST_01      16'hFFFF
`define FSR_V_CONST_02      16'h1234
`define FSR_V_CONST_03      16'hAAAA
`define FSR_V_CONST_04      16'h5555
`define FSR_V_CONST_05      16'h7FFF
`define FSR_V_CONST_06      16'h8000
`define FSR_V_CONST_07      16'h3FFF
`define FSR_V_CONST_08      16'h4000

// ----------------------------------------
// Watchdog codes and fields
// ----------------------------------------
`define FSR_CMD_START       16'h5555
`define FSR_CMD_STOP        16'h55AA
`define FSR_CMD_RESET       16'hAAAA
`define FSR_WS_NO_TIMEOUT   16'hFFFF
`define FSR_WS_STOPPED      16'h0000
`define FSR_WS_RUNNING      16'h0001
`define FSR_WS_EXPIRED      16'h0002
`define FSR_MODE_STANDARD   16'h0000
`define FSR_MODE_AUTO_START 16'h0001
`define FSR_CFG_EXPLICIT    0
`define FSR_CFG_STAT_TRIG   1
`define FSR_CFG_CLOSE_TCP   2
`define FSR_CFG_MASK        16'h0007

// ----------------------------------------
// Exception codes
// ----------------------------------------
`define FSR_EXC_NONE        8'h00
`define FSR_EXC_ILL_FUNC    8'h01
`define FSR_EXC_ILL_ADDR    8'h02
`define FSR_EXC_ILL_VALUE   8'h03

// ----------------------------------------
// Timing
// ----------------------------------------
`define FSR_CLK_HZ          125000000
`define FSR_WD_STEP_MS      100
`define FSR_DLY_UNIT_MS     1
`define FSR_WD_STEP_CYC     (`FSR_CLK_HZ / 1000 * `FSR_WD_STEP_MS)
`define FSR_DLY_UNIT_CYC    (`FSR_CLK_HZ / 1000 * `FSR_DLY_UNIT_MS)
`define FSR_RSP_DLY_MAX_MS  16'h0020
`define FSR_MAX_TCP_CONN    1000
`define FSR_TICK_W          24
`define FSR_MS_W            17

`endif

/* File: fsr_pkg.sv */
`include "fsr_consts.svh"

package fsr_pkg;

  typedef enum logic [1:0] {
    FSR_WD_NO_TIMEOUT,
    FSR_WD_STOPPED,
    FSR_WD_RUNNING,
    FSR_WD_EXPIRED
  } fsr_wd_e;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } fsr_req_t;

  typedef struct packed {
    logic [7:0]  exc;
    logic [15:0] data;
  } fsr_rsp_t;

  typedef struct packed {
    logic [15:0] tcp_conn_cnt;
    logic [15:0] ip_method;
    logic [15:0] run_state;
    logic [47:0] hw_addr;
  } fsr_info_t;

  typedef struct packed {
    fsr_wd_e                wd;
    logic                   mode_auto_start;
    logic [15:0]            wd_cfg;
    logic [15:0]            wd_timeout;
    logic [15:0]            wd_steps;
    logic [`FSR_TICK_W-1:0] wd_tick;
    logic [15:0]            sock_timeout;
    logic [15:0]            rsp_delay;
    logic [15:0]            dly_left;
    logic [`FSR_MS_W-1:0]   ms_cnt;
    logic                   rdy;
    logic                   pend;
    logic                   rsp_valid;
    fsr_rsp_t               rsp;
    logic                   close_all;
    logic                   wd_expired;
  } fsr_state_t;

endpackage

/* File: fsr_info_regs_wdog.sv */
`timescale 1ns/1ps
`include "fsr_consts.svh"

module fsr_info_regs_wdog
  import fsr_pkg::*;
#(
  parameter logic [15:0] IN_REG_CNT    = 16'h03E8,
  parameter logic [15:0] OUT_REG_CNT   = 16'h03E8,
  parameter logic [15:0] IN_BIT_CNT    = 16'h3E80,
  parameter logic [15:0] OUT_BIT_CNT   = 16'h3E80,
  parameter int          WD_STEP_CYC   = `FSR_WD_STEP_CYC,
  parameter int          DLY_UNIT_CYC  = `FSR_DLY_UNIT_CYC,
  // Identity words: values are arbitrary
  parameter logic [15:0] FW_REV        = 16'h0001,
  parameter logic [15:0] SERIES_CODE   = 16'h0001,
  parameter logic [15:0] DEVICE_CODE   = 16'h0001,
  parameter logic [15:0] FW_MAJOR      = 16'h0001,
  parameter logic [15:0] FW_MINOR      = 16'h0000,
  parameter logic [15:0] STACK_VER     = 16'h0001
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_req_valid,
  input  wire fsr_req_t    i_req,
  input  wire logic        i_svc_trigger,
  input  wire fsr_info_t   i_info,
  output logic             o_req_ready,
  output logic             o_rsp_valid,
  output fsr_rsp_t         o_rsp,
  output logic [15:0]      o_sock_timeout,
  output logic             o_close_all_conn,
  output logic             o_wd_expired
);

  localparam logic [`FSR_TICK_W-1:0] TICK_LAST = `FSR_TICK_W'(WD_STEP_CYC - 1);
  localparam logic [`FSR_MS_W-1:0]   MS_LAST   = `FSR_MS_W'(DLY_UNIT_CYC - 1);

  fsr_state_t st_r;
  fsr_state_t st_nxt;

  logic        acc;
  logic        trig;
  logic        wr;
  logic [15:0] wd;
  logic [15:0] rdata;
  logic [7:0]  exc;
  logic [15:0] state_code;

  // ----------------------------------------
  // Watchdog state code
  // ----------------------------------------
  always_comb begin
    unique case (st_r.wd)
      FSR_WD_NO_TIMEOUT: state_code = `FSR_WS_NO_TIMEOUT;
      FSR_WD_STOPPED:    state_code = `FSR_WS_STOPPED;
      FSR_WD_RUNNING:    state_code = `FSR_WS_RUNNING;
      FSR_WD_EXPIRED:    state_code = `FSR_WS_EXPIRED;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.rsp_valid = 1'b0;
    st_nxt.close_all = 1'b0;
    acc              = i_req_valid && st_r.rdy;
    wr               = i_req.write;
    wd               = i_req.wdata;
    rdata            = 16'h0000;
    exc              = `FSR_EXC_NONE;
    trig             = 1'b0;

    // ----------------------------------------
    // Timeout countdown while running
    // ----------------------------------------
    if (st_r.wd == FSR_WD_RUNNING) begin
      if (st_r.wd_tick == TICK_LAST) begin
        st_nxt.wd_tick = '0;
        if (st_r.wd_steps + 16'h0001 >= st_r.wd_timeout) begin
          st_nxt.wd        = FSR_WD_EXPIRED;
          st_nxt.close_all = st_r.wd_cfg[`FSR_CFG_CLOSE_TCP];
        end else begin
          st_nxt.wd_steps = st_r.wd_steps + 16'h0001;
        end
      end else begin
        st_nxt.wd_tick = st_r.wd_tick + `FSR_TICK_W'(1);
      end
    end

    if (acc) begin
      unique case (i_req.addr)
        `FSR_A_IN_REG_CNT:   rdata = IN_REG_CNT;
        `FSR_A_OUT_REG_CNT:  rdata = OUT_REG_CNT;
        `FSR_A_IN_BIT_CNT:   rdata = IN_BIT_CNT;
        `FSR_A_OUT_BIT_CNT:  rdata = OUT_BIT_CNT;
        `FSR_A_IP_METHOD:    rdata = i_info.ip_method;
        `FSR_A_TCP_CONN_CNT: rdata = i_info.tcp_conn_cnt;
        `FSR_A_HW_ADDR0:     rdata = i_info.hw_addr[47:32];
        `FSR_A_HW_ADDR1:     rdata = i_info.hw_addr[31:16];
        `FSR_A_HW_ADDR2:     rdata = i_info.hw_addr[15:0];
        `FSR_A_RUN_STATE:    rdata = i_info.run_state;
        `FSR_A_WD_STATE:     rdata = state_code;
        `FSR_A_CONST_00:     rdata = `FSR_V_CONST_00;
        `FSR_A_CONST_01:     rdata = `FSR_V_CONST_01;
        `FSR_A_CONST_02:     rdata = `FSR_V_CONST_02;
        `FSR_A_CONST_03:     rdata = `FSR_V_CONST_03;
        `FSR_A_CONST_04:     rdata = `FSR_V_CONST_04;
        `FSR_A_CONST_05:     rdata = `FSR_V_CONST_05;
        `FSR_A_CONST_06:     rdata = `FSR_V_CONST_06;
        `FSR_A_CONST_07:     rdata = `FSR_V_CONST_07;
        `FSR_A_CONST_08:     rdata = `FSR_V_CONST_08;
        `FSR_A_FW_REV:       rdata = FW_REV;
        `FSR_A_SERIES:       rdata = SERIES_CODE;
        `FSR_A_DEVICE:       rdata = DEVICE_CODE;
        `FSR_A_FW_MAJOR:     rdata = FW_MAJOR;
        `FSR_A_FW_MINOR:     rdata = FW_MINOR;
        `FSR_A_STACK_VER:    rdata = STACK_VER;
        `FSR_A_SOCK_TIMEOUT: begin
          rdata = st_r.sock_timeout;
          if (wr) begin
            st_nxt.sock_timeout = wd;
          end
        end
        `FSR_A_RSP_DELAY: begin
          rdata = st_r.rsp_delay;
          if (wr) begin
            if (wd > `FSR_RSP_DLY_MAX_MS) begin
              exc = `FSR_EXC_ILL_VALUE;
            end else begin
              st_nxt.rsp_delay = wd;
            end
          end
        end
        `FSR_A_WD_CONFIG: begin
          rdata = st_r.wd_cfg;
          if (wr) begin
            st_nxt.wd_cfg = wd & `FSR_CFG_MASK;
          end
        end
        `FSR_A_WD_MODE: begin
          rdata = st_r.mode_auto_start ? `FSR_MODE_AUTO_START : `FSR_MODE_STANDARD;
          if (wr) begin
            if (wd == `FSR_MODE_STANDARD) begin
              st_nxt.mode_auto_start = 1'b0;
              if (st_r.mode_auto_start && st_r.wd_timeout != 16'h0000) begin
                st_nxt.wd = FSR_WD_STOPPED;
              end
            end else if (wd == `FSR_MODE_AUTO_START) begin
              st_nxt.mode_auto_start = 1'b1;
              if (st_r.wd_timeout != 16'h0000 && st_r.wd != FSR_WD_EXPIRED) begin
                st_nxt.wd = FSR_WD_RUNNING;
              end
            end else begin
              exc = `FSR_EXC_ILL_VALUE;
            end
          end
        end
        `FSR_A_WD_TIMEOUT: begin
          rdata = st_r.wd_timeout;
          if (wr) begin
            if (st_r.wd == FSR_WD_RUNNING) begin
              exc = `FSR_EXC_ILL_FUNC;
            end else begin
              st_nxt.wd_timeout = wd;
              if (wd == 16'h0000) begin
                st_nxt.wd = FSR_WD_NO_TIMEOUT;
              end else if (st_r.mode_auto_start) begin
                st_nxt.wd = FSR_WD_RUNNING;
              end else if (st_r.wd == FSR_WD_NO_TIMEOUT) begin
                st_nxt.wd = FSR_WD_STOPPED;
              end
            end
          end
        end
        `FSR_A_WD_CMD: begin
          rdata = 16'h0000;
          if (wr) begin
            if (st_r.wd == FSR_WD_NO_TIMEOUT) begin
              exc = `FSR_EXC_ILL_VALUE;
            end else if (wd == `FSR_CMD_START) begin
              if (st_r.wd == FSR_WD_EXPIRED && !st_r.mode_auto_start) begin
                exc = `FSR_EXC_ILL_FUNC;
              end else begin
                st_nxt.wd = FSR_WD_RUNNING;
                trig      = 1'b1;
              end
            end else if (wd == `FSR_CMD_STOP) begin
              if (st_r.mode_auto_start) begin
                exc = `FSR_EXC_ILL_VALUE;
              end else if (st_r.wd == FSR_WD_EXPIRED) begin
                exc = `FSR_EXC_ILL_FUNC;
              end else begin
                st_nxt.wd = FSR_WD_STOPPED;
              end
            end else if (wd == `FSR_CMD_RESET) begin
              if (st_r.wd == FSR_WD_EXPIRED && !st_r.mode_auto_start) begin
                st_nxt.wd = FSR_WD_STOPPED;
              end else begin
                exc = `FSR_EXC_ILL_VALUE;
              end
            end else begin
              exc = `FSR_EXC_ILL_VALUE;
            end
          end
        end
        default: begin
          exc = `FSR_EXC_ILL_ADDR;
        end
      endcase

      // ----------------------------------------
      // Writes to read-only words are refused unchanged
      // ----------------------------------------
      if (wr && exc == `FSR_EXC_NONE) begin
        unique case (i_req.addr)
          `FSR_A_SOCK_TIMEOUT, `FSR_A_RSP_DELAY, `FSR_A_WD_CONFIG,
          `FSR_A_WD_MODE, `FSR_A_WD_TIMEOUT, `FSR_A_WD_CMD: ;
          default: exc = `FSR_EXC_ILL_ADDR;
        endcase
      end
      if (!wr && i_req.addr == `FSR_A_WD_CMD) begin
        exc = `FSR_EXC_ILL_ADDR;
      end

      // ----------------------------------------
      // Valid requests retrigger unless explicit mode; watchdog state reads only with the status trigger bit set
      // ----------------------------------------
      if (exc == `FSR_EXC_NONE && !st_r.wd_cfg[`FSR_CFG_EXPLICIT]) begin
        if (wr || i_req.addr != `FSR_A_WD_STATE || st_r.wd_cfg[`FSR_CFG_STAT_TRIG]) begin
          trig = 1'b1;
        end
      end

      // ----------------------------------------
      // Response capture, held for the programmed delay
      // ----------------------------------------
      st_nxt.rsp.data = (exc == `FSR_EXC_NONE) ? rdata : 16'h0000;
      st_nxt.rsp.exc  = exc;
      st_nxt.ms_cnt   = '0;
      if (st_r.rsp_delay == 16'h0000) begin
        st_nxt.rsp_valid = 1'b1;
      end else begin
        st_nxt.dly_left = st_r.rsp_delay;
        st_nxt.pend     = 1'b1;
        st_nxt.rdy      = 1'b0;
      end
    end else if (st_r.pend) begin
      if (st_r.ms_cnt == MS_LAST) begin
        st_nxt.ms_cnt = '0;
        if (st_r.dly_left == 16'h0001) begin
          st_nxt.pend      = 1'b0;
          st_nxt.rdy       = 1'b1;
          st_nxt.rsp_valid = 1'b1;
        end else begin
          st_nxt.dly_left = st_r.dly_left - 16'h0001;
        end
      end else begin
        st_nxt.ms_cnt = st_r.ms_cnt + `FSR_MS_W'(1);
      end
    end

    // ----------------------------------------
    // Other services retrigger as well
    // ----------------------------------------
    if (i_svc_trigger && !st_r.wd_cfg[`FSR_CFG_EXPLICIT]) begin
      trig = 1'b1;
    end

    // ----------------------------------------
    // Trigger restarts the watchdog; a trigger in the expiry cycle wins
    // ----------------------------------------
    if (trig) begin
      if (st_nxt.wd == FSR_WD_RUNNING || st_nxt.wd == FSR_WD_EXPIRED) begin
        if (st_r.wd == FSR_WD_RUNNING || st_r.mode_auto_start ||
            st_nxt.wd == FSR_WD_RUNNING) begin
          if (st_nxt.wd == FSR_WD_RUNNING || st_r.mode_auto_start ||
              st_r.wd == FSR_WD_RUNNING) begin
            st_nxt.wd        = FSR_WD_RUNNING;
            st_nxt.close_all = 1'b0;
          end
        end
      end
    end
    if (st_nxt.wd == FSR_WD_RUNNING && (trig || st_r.wd != FSR_WD_RUNNING)) begin
      st_nxt.wd_tick  = '0;
      st_nxt.wd_steps = 16'h0000;
    end
    st_nxt.wd_expired = (st_nxt.wd == FSR_WD_EXPIRED);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st_r     <= '0;
      st_r.wd  <= FSR_WD_NO_TIMEOUT;
      st_r.rdy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_req_ready      = st_r.rdy;
  assign o_rsp_valid      = st_r.rsp_valid;
  assign o_rsp            = st_r.rsp;
  assign o_sock_timeout   = st_r.sock_timeout;
  assign o_close_all_conn = st_r.close_all;
  assign o_wd_expired     = st_r.wd_expired;

endmodule

/* File: fsr_info_regs_wdog_properties.sv */
`timescale 1ns/1ps
module fsr_info_regs_wdog_properties
  import fsr_pkg::*;
#(
  parameter int DLY_UNIT_CYC = 4
) (
  input wire logic        i_clk_sys,
  input wire logic        i_nrst,
  input wire logic        i_req_valid,
  input wire fsr_req_t    i_req,
  input wire logic        i_svc_trigger,
  input wire fsr_info_t   i_info,
  input wire logic        o_req_ready,
  input wire logic        o_rsp_valid,
  input wire fsr_rsp_t    o_rsp,
  input wire logic [15:0] o_sock_timeout,
  input wire logic        o_close_all_conn,
  input wire logic        o_wd_expired
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  logic        take;
  logic        bad;
  logic        bad_r;
  logic        sock_wr_r;
  logic [31:0] low_cnt_r;
  assign take = i_req_valid && o_req_ready;
  // ----------------------------------------
  // Addresses that must be refused
  // ----------------------------------------
  always_comb begin
    case (i_req.addr)
      16'h1022, 16'h1023, 16'h1024, 16'h1025, 16'h1028, 16'h102A, 16'h1031, 16'h1032,
      16'h1033, 16'h1040, 16'h1101, 16'h2000, 16'h2001, 16'h2002, 16'h2003, 16'h2004,
      16'h2005, 16'h2006, 16'h2007, 16'h2008, 16'h2010, 16'h2011, 16'h2012, 16'h2013,
      16'h2014, 16'h2015: bad = i_req.write;
      16'h1030, 16'h1037, 16'h1102, 16'h1103, 16'h1104: bad = 1'b0;
      16'h1100: bad = !i_req.write;
      default: bad = 1'b1;
    endcase
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      bad_r     <= 1'b0;
      sock_wr_r <= 1'b0;
      low_cnt_r <= 32'h00000000;
    end else begin
      if (take) begin
        bad_r     <= bad;
        sock_wr_r <= i_req.write && (i_req.addr == 16'h1030);
      end
      low_cnt_r <= o_req_ready ? 32'h00000000 : low_cnt_r + 32'h00000001;
    end
  end
  a_reset_idle: assert property (
    $rose(i_nrst) |-> o_req_ready && !o_rsp_valid && !o_wd_expired && o_sock_timeout == 16'h0000)
    else $error("outputs not idle after reset");
  a_zero_delay: assert property (
    take ##1 o_req_ready |-> o_rsp_valid) else $error("undelayed answer missing");
  a_busy_quiet: assert property (
    !o_req_ready |-> !o_rsp_valid) else $error("answer while busy");
  a_ready_rsp: assert property (
    $rose(o_req_ready) |-> o_rsp_valid) else $error("ready back without answer");
  a_delay_units: assert property (
    $rose(o_req_ready) |-> (low_cnt_r % DLY_UNIT_CYC == 0)
      && low_cnt_r inside {[DLY_UNIT_CYC:32*DLY_UNIT_CYC]}) else $error("delay length wrong");
  a_bad_addr: assert property (
    o_rsp_valid && bad_r |-> o_rsp.exc == 8'h02) else $error("missing address exception");
  a_exc_no_data: assert property (
    o_rsp_valid && o_rsp.exc != 8'h00 |-> o_rsp.data == 16'h0000) else $error("data on exception");
  a_close_on_exp: assert property (
    o_close_all_conn |-> $rose(o_wd_expired)) else $error("close pulse outside expiry");
  a_sock_change: assert property (
    $changed(o_sock_timeout) |-> sock_wr_r) else $error("socket timeout changed unasked");
  c_write: cover property (take && i_req.write);
  c_delayed: cover property ($rose(o_req_ready));
  c_expiry: cover property ($rose(o_wd_expired));
  c_close: cover property (o_close_all_conn);
endmodule

bind fsr_info_regs_wdog fsr_info_regs_wdog_properties #(.DLY_UNIT_CYC(DLY_UNIT_CYC)) u_props (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_req_valid(i_req_valid), .i_req(i_req),
  .i_svc_trigger(i_svc_trigger), .i_info(i_info), .o_req_ready(o_req_ready),
  .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_sock_timeout(o_sock_timeout),
  .o_close_all_conn(o_close_all_conn), .o_wd_expired(o_wd_expired));

/* File: fsr_master.sv */
`timescale 1ns/1ps
module fsr_master
  import fsr_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_req_ready,
  output logic      o_req_valid,
  output fsr_req_t  o_req
);
  initial begin
    o_req_valid = 1'b0;
    o_req       = '0;
  end
  // Request held until the edge that takes it
  task automatic xfer(input fsr_req_t r, output bit ok);
    int n;
    ok = 1'b0;
    o_req_valid <= 1'b1;
    o_req       <= r;
    for (n = 0; n < 400; n++) begin
      @(negedge i_clk_sys);
      if (i_req_ready === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
    @(posedge i_clk_sys);
  endtask
  // Released lines show the inverse; a second drop in a row restores the stale request
  task automatic drop();
    o_req_valid <= 1'b0;
    o_req       <= ~o_req;
  endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench
  import fsr_pkg::*;
;
  logic        i_clk_sys = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_svc_trigger = 1'b0;
  logic        i_req_valid;
  fsr_req_t    i_req;
  fsr_info_t   i_info;
  logic        o_req_ready;
  logic        o_rsp_valid;
  fsr_rsp_t    o_rsp;
  logic [15:0] o_sock_timeout;
  logic        o_close_all_conn;
  logic        o_wd_expired;
  logic [24:0] exp_q[$];
  logic [24:0] e;
  logic [15:0] ra[25];
  logic [15:0] rv[25];
  logic [15:0] sv;
  int          seed = 32'hF240;
  int          mismatches = 0;
  int          checks_done = 0;
  int          close_cnt = 0;
  int          i;
  always #4 i_clk_sys = ~i_clk_sys;
  fsr_info_regs_wdog #(.WD_STEP_CYC(10), .DLY_UNIT_CYC(4)) u_dut (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_req_valid(i_req_valid), .i_req(i_req),
    .i_svc_trigger(i_svc_trigger), .i_info(i_info), .o_req_ready(o_req_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_sock_timeout(o_sock_timeout),
    .o_close_all_conn(o_close_all_conn), .o_wd_expired(o_wd_expired));
  fsr_master u_mst (.i_clk_sys(i_clk_sys), .i_req_ready(o_req_ready),
    .o_req_valid(i_req_valid), .o_req(i_req));
  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rq(input logic w, input logic [15:0] a, input logic [15:0] d,
                    input logic [7:0] x);
    fsr_req_t r;
    bit       ok;
    r = '{write: w, addr: a, wdata: d};
    exp_q.push_back({!w, x, d});
    u_mst.xfer(r, ok);
    if (!ok) begin
      mismatches++;
      results();
    end
  endtask
  task automatic idle(input int n);
    u_mst.drop();
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic pulse();
    i_svc_trigger <= 1'b1;
    @(posedge i_clk_sys);
    i_svc_trigger <= 1'b0;
  endtask
  task automatic wait_exp(input int lo, input int hi);
    int n;
    u_mst.drop();
    for (n = 1; n <= hi + 5; n++) begin
      @(negedge i_clk_sys);
      if (o_wd_expired === 1'b1) break;
    end
    check(48'(n >= lo && n <= hi), 48'h1);
    if (o_wd_expired !== 1'b1) results();
    @(posedge i_clk_sys);
  endtask
  // ----------------------------------------
  // Answer monitor
  // ----------------------------------------
  always @(negedge i_clk_sys) begin
    if (o_close_all_conn === 1'b1) close_cnt++;
    if (o_rsp_valid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 25'h1FFFFFF;
      check({o_rsp.exc, e[24] ? o_rsp.data : 16'h0000},
            {e[23:16], e[24] ? e[15:0] : 16'h0000});
    end
  end
  initial begin
    i_info = {$random(seed), $random(seed), $random(seed)};
    ra = '{16'h2000, 16'h2001, 16'h2002, 16'h2003, 16'h2004, 16'h2005, 16'h2006, 16'h2007,
           16'h2008, 16'h1022, 16'h1023, 16'h1024, 16'h1025, 16'h1028, 16'h102A, 16'h1031,
           16'h1032, 16'h1033, 16'h1040, 16'h1101, 16'h1102, 16'h1103, 16'h1104, 16'h1037,
           16'h1030};
    rv = '{16'h0000, 16'hFFFF, 16'h1234, 16'hAAAA, 16'h5555, 16'h7FFF, 16'h8000, 16'h3FFF,
           16'h4000, 16'h03E8, 16'h03E8, 16'h3E80, 16'h3E80, i_info.ip_method,
           i_info.tcp_conn_cnt, i_info.hw_addr[47:32], i_info.hw_addr[31:16],
           i_info.hw_addr[15:0], i_info.run_state, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000,
           16'h0000, 16'h0000};
    repeat (12) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    @(posedge i_clk_sys);
    for (i = 0; i < 25; i++) rq(1'b0, ra[i], rv[i], 8'h00);
    rq(1'b0, 16'h1100, 16'h0000, 8'h02);
    rq(1'b0, 16'h1026, 16'h0000, 8'h02);
    rq(1'b0, 16'h2009, 16'h0000, 8'h02);
    rq(1'b1, 16'h2002, 16'h0000, 8'h02);
    rq(1'b0, 16'h2002, 16'h1234, 8'h00);
    sv = $random(seed);
    rq(1'b1, 16'h1030, sv, 8'h00);
    rq(1'b0, 16'h1030, sv, 8'h00);
    idle(2);
    check(o_sock_timeout, sv);
    rq(1'b1, 16'h1037, 16'h0021, 8'h03);
    rq(1'b1, 16'h1037, 16'h0020, 8'h00);
    rq(1'b0, 16'h1037, 16'h0020, 8'h00);
    rq(1'b1, 16'h1037, 16'h0001, 8'h00);
    rq(1'b1, 16'h1037, 16'h0000, 8'h00);
    rq(1'b1, 16'h1100, 16'h5555, 8'h03);
    rq(1'b1, 16'h1103, 16'h0004, 8'h00);
    rq(1'b1, 16'h1102, 16'h0003, 8'h00);
    rq(1'b0, 16'h1101, 16'h0000, 8'h00);
    rq(1'b1, 16'h1100, 16'h55AA, 8'h00);
    rq(1'b1, 16'h1100, 16'hAAAA, 8'h03);
    rq(1'b1, 16'h1100, 16'h1234, 8'h03);
    rq(1'b1, 16'h1100, 16'h5555, 8'h00);
    rq(1'b0, 16'h1101, 16'h0001, 8'h00);
    rq(1'b1, 16'h1102, 16'h0005, 8'h01);
    idle(1);
    for (i = 0; i < 4; i++) begin
      pulse();
      repeat (19) @(posedge i_clk_sys);
    end
    check(o_wd_expired, 1'b0);
    wait_exp(9, 13);
    check(close_cnt, 1);
    rq(1'b0, 16'h1101, 16'h0002, 8'h00);
    rq(1'b1, 16'h1100, 16'h5555, 8'h01);
    rq(1'b1, 16'h1100, 16'h55AA, 8'h01);
    rq(1'b1, 16'h1100, 16'hAAAA, 8'h00);
    rq(1'b1, 16'h1103, 16'h0001, 8'h00);
    rq(1'b1, 16'h1100, 16'h5555, 8'h00);
    rq(1'b0, 16'h2002, 16'h1234, 8'h00);
    idle(10);
    pulse();
    wait_exp(16, 22);
    check(close_cnt, 1);
    rq(1'b1, 16'h1100, 16'hAAAA, 8'h00);
    rq(1'b1, 16'h1103, 16'h0000, 8'h00);
    rq(1'b1, 16'h1102, 16'h0000, 8'h00);
    rq(1'b0, 16'h1101, 16'hFFFF, 8'h00);
    rq(1'b1, 16'h1104, 16'h0002, 8'h03);
    rq(1'b1, 16'h1104, 16'h0001, 8'h00);
    rq(1'b1, 16'h1102, 16'h0002, 8'h00);
    rq(1'b0, 16'h1101, 16'h0001, 8'h00);
    rq(1'b1, 16'h1100, 16'h55AA, 8'h03);
    rq(1'b1, 16'h1100, 16'hAAAA, 8'h03);
    rq(1'b1, 16'h1100, 16'h5555, 8'h00);
    wait_exp(18, 23);
    rq(1'b0, 16'h2000, 16'h0000, 8'h00);
    rq(1'b0, 16'h1101, 16'h0001, 8'h00);
    wait_exp(16, 23);
    rq(1'b1, 16'h1102, 16'h0000, 8'h00);
    rq(1'b0, 16'h1101, 16'hFFFF, 8'h00);
    rq(1'b1, 16'h1102, 16'h0002, 8'h00);
    rq(1'b1, 16'h1104, 16'h0000, 8'h00);
    rq(1'b0, 16'h1101, 16'h0000, 8'h00);
    rq(1'b1, 16'h1103, 16'h0002, 8'h00);
    rq(1'b1, 16'h1100, 16'h5555, 8'h00);
    for (i = 0; i < 3; i++) begin
      idle(14);
      rq(1'b0, 16'h1101, 16'h0001, 8'h00);
    end
    wait_exp(18, 22);
    idle(4);
    check(exp_q.size(), 0);
    results();
  end
endmodule
